// [rtl/playback_pkg.sv]
// shared constants for the playback command decoder and its host end
// assumes a 50 MHz clock on both ends
package playback_pkg;
  localparam int CLK_HZ = 50000000;
  localparam int NCH = 4;
  localparam int PHRASE_W = 10;
  localparam logic [3:0] OP_POWER_DOWN = 4'h2;
  localparam logic [3:0] OP_PHRASE_SELECT = 4'h3;
  localparam logic [3:0] OP_DIRECT_PHRASE = 4'h4;
  localparam logic [3:0] OP_LAUNCH = 4'h5;
  localparam logic [3:0] OP_HALT = 4'h6;
  localparam logic [3:0] OP_SILENCE_INSERT = 4'h7;
  localparam logic [3:0] OP_LOOP_SET = 4'h8;
  localparam logic [3:0] OP_LOOP_RELEASE = 4'h9;
  localparam int SILENCE_STEP_US = 4000;
  localparam int SILENCE_STEP_CYC = SILENCE_STEP_US * (CLK_HZ / 1000000);
  localparam logic [7:0] SILENCE_CODE_MIN = 8'h04;
  localparam int POWER_DOWN_PROC_TIME_US = 10;
  localparam int POWER_DOWN_PROC_CYC =
    POWER_DOWN_PROC_TIME_US * (CLK_HZ / 1000000);
  localparam int BUSY_LOW_TIME_HALT_US = 20;
  localparam int BUSY_LOW_HALT_CYC =
    BUSY_LOW_TIME_HALT_US * (CLK_HZ / 1000000);
  localparam int PHRASE_LEN_CYC = 5000;
  localparam int CNT_W = 24;
endpackage

// [rtl/playback_link_if.sv]
// byte link between host and command decoder, plus per-channel flags
// assumes both ends share REF_CLK
`timescale 1ns/10ps
interface playback_link_if;
  logic [7:0] cmd_byte;
  logic cmd_valid;
  logic [3:0] cmd_ready_flag;
  logic [3:0] channel_busy_n;
  logic powered_down;
  modport device (input cmd_byte, input cmd_valid, output cmd_ready_flag,
    output channel_busy_n, output powered_down);
  modport host (output cmd_byte, output cmd_valid, input cmd_ready_flag,
    input channel_busy_n, input powered_down);
endinterface

// [rtl/playback_command_decoder.sv]
// device end: decodes host command bytes and runs four channel sequencers
// assumes byte strobes and flags on REF_CLK; the host keeps its own rules
// Overview of operation
// - power-down ignored while any channel busy
// - power-down resets settings, then stops clock
// - phrase select: opcode, phrase hi, channel; lo
// - phrase select stores phrase, needs ready flag
// - host uses phrase numbers 0 to 1023
// - direct direct_phrase_cmd starts phrase at once
// - launch plays stored phrase on masked channels
// - zero channel mask commands are discarded
// - halt stops channel, ready and busy high
// - halt accepted regardless of ready flag
// - host waits busy-low time after halt
// - host repeats halt if busy stays low
// - silence: mask byte then duration code byte
// - gap lasts (code plus one) times 4 ms; for codes above 82 the 24-bit count wraps
// - host never programs silence code below 04
// - silence gaps never loop
// - loop set replays phrase until released
// - loop replays the phrase alone; a gap ending clears loop
// - loop release accepted regardless of ready
// - loop release drives ready flag high
`timescale 1ns/10ps
module playback_command_decoder
#(
  parameter int PHRASE_CYC = playback_pkg::PHRASE_LEN_CYC,
  parameter int SILENCE_CYC = playback_pkg::SILENCE_STEP_CYC,
  parameter int PD_CYC = playback_pkg::POWER_DOWN_PROC_CYC
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CE,
  playback_link_if.device LINK,
  output logic OSC_RUN,
  output logic [4*playback_pkg::PHRASE_W-1:0] DIRECT_PHRASE_CMD_PHRASE,
  output logic [3:0] PLAYING
);
  import playback_pkg::*;

  typedef enum logic [1:0] {CH_IDLE, CH_DIRECT_PHRASE_CMD, CH_SILENCE} ch_state_t;
  typedef enum logic [1:0] {D_FIRST, D_SECOND, D_POWER_DOWN_CMD, D_OFF} dec_state_t;

  ////////////////////////////////////////////////////////////////////////
  // command byte gathering

  function automatic logic two_byte(input logic [3:0] op);
    return op == OP_PHRASE_SELECT || op == OP_DIRECT_PHRASE ||
      op == OP_SILENCE_INSERT;
  endfunction

  dec_state_t dec_reg, dec_next;
  logic [7:0] first_reg, first_next;
  logic [CNT_W-1:0] pd_cnt_reg, pd_cnt_next;
  logic exec;
  logic [7:0] b1, b2;
  logic osc_reg, osc_next;

  ch_state_t st_reg [NCH], st_next [NCH];
  logic [PHRASE_W-1:0] phr_reg [NCH], phr_next [NCH];
  logic [3:0] loop_reg, loop_next;
  logic [CNT_W-1:0] cnt_reg [NCH], cnt_next [NCH];
  logic [3:0] rdy_reg, rdy_next, bsy_n_reg, bsy_n_next;
  logic [NCH*PHRASE_W-1:0] pp_reg, pp_next;
  logic [3:0] direct_phrase_cmd_reg, direct_phrase_cmd_next;

  always_comb begin
    dec_next = dec_reg;
    first_next = first_reg;
    pd_cnt_next = pd_cnt_reg;
    osc_next = osc_reg;
    exec = 1'b0;
    b1 = first_reg;
    b2 = LINK.cmd_byte;
    unique case (dec_reg)
      D_FIRST: begin
        if (LINK.cmd_valid) begin
          b1 = LINK.cmd_byte;
          if (two_byte(LINK.cmd_byte[7:4])) begin
            first_next = LINK.cmd_byte;
            dec_next = D_SECOND;
          end else if (LINK.cmd_byte[7:4] == OP_POWER_DOWN) begin
            if (&bsy_n_reg) begin
              dec_next = D_POWER_DOWN_CMD;
              pd_cnt_next = '0;
            end
          end else begin
            exec = 1'b1;
          end
        end
      end
      D_SECOND: begin
        if (LINK.cmd_valid) begin
          exec = 1'b1;
          dec_next = D_FIRST;
        end
      end
      D_POWER_DOWN_CMD: begin
        if (pd_cnt_reg == CNT_W'(PD_CYC - 1)) begin
          dec_next = D_OFF;
          osc_next = 1'b0;
        end else begin
          pd_cnt_next = pd_cnt_reg + 1'b1;
        end
      end
      D_OFF: begin
        // clock stays halted until the next chip reset
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      dec_reg <= D_FIRST;
      first_reg <= 8'h00;
      pd_cnt_reg <= '0;
      osc_reg <= 1'b1;
    end else if (CE) begin
      dec_reg <= dec_next;
      first_reg <= first_next;
      pd_cnt_reg <= pd_cnt_next;
      osc_reg <= osc_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-channel sequencers

  logic [3:0] mask;
  logic [3:0] op;
  logic [1:0] code;
  logic [PHRASE_W-1:0] phrase_in;
  assign op = b1[7:4];
  assign mask = b1[3:0];
  assign code = b1[1:0];
  assign phrase_in = {b1[3:2], b2};

  always_comb begin
    loop_next = loop_reg;
    rdy_next = rdy_reg;
    bsy_n_next = bsy_n_reg;
    direct_phrase_cmd_next = direct_phrase_cmd_reg;
    for (int i = 0; i < NCH; i++) begin
      st_next[i] = st_reg[i];
      phr_next[i] = phr_reg[i];
      cnt_next[i] = cnt_reg[i];
      // end of a phrase or gap
      if (st_reg[i] != CH_IDLE) begin
        if (cnt_reg[i] == '0) begin
          // a gap never reloads, so loop mode only replays phrases
          if (st_reg[i] == CH_DIRECT_PHRASE_CMD && loop_reg[i]) begin
            cnt_next[i] = CNT_W'(PHRASE_CYC - 1);
          end else begin
            st_next[i] = CH_IDLE;
            rdy_next[i] = 1'b1;
            bsy_n_next[i] = 1'b1;
            loop_next[i] = 1'b0;
          end
        end else begin
          cnt_next[i] = cnt_reg[i] - 1'b1;
        end
      end
      if (exec) begin
        unique case (op)
          OP_PHRASE_SELECT:
            if (code == 2'(i) && rdy_reg[i]) phr_next[i] = phrase_in;
          OP_DIRECT_PHRASE:
            if (code == 2'(i) && rdy_reg[i]) begin
              phr_next[i] = phrase_in;
              st_next[i] = CH_DIRECT_PHRASE_CMD;
              cnt_next[i] = CNT_W'(PHRASE_CYC - 1);
              rdy_next[i] = 1'b0;
              bsy_n_next[i] = 1'b0;
            end
          // a zero mask selects no channel, so nothing changes
          OP_LAUNCH:
            if (mask[i] && rdy_reg[i]) begin
              st_next[i] = CH_DIRECT_PHRASE_CMD;
              cnt_next[i] = CNT_W'(PHRASE_CYC - 1);
              rdy_next[i] = 1'b0;
              bsy_n_next[i] = 1'b0;
            end
          OP_HALT:
            if (mask[i]) begin
              st_next[i] = CH_IDLE;
              loop_next[i] = 1'b0;
              rdy_next[i] = 1'b1;
              bsy_n_next[i] = 1'b1;
            end
          OP_SILENCE_INSERT:
            if (mask[i] && rdy_reg[i]) begin
              st_next[i] = CH_SILENCE;
              cnt_next[i] = CNT_W'(({16'h0000, b2} + 24'h000001) *
                CNT_W'(SILENCE_CYC) - 1);
              rdy_next[i] = 1'b0;
              bsy_n_next[i] = 1'b0;
            end
          OP_LOOP_SET:
            if (mask[i] && rdy_reg[i]) loop_next[i] = 1'b1;
          OP_LOOP_RELEASE:
            if (mask[i]) begin
              loop_next[i] = 1'b0;
              rdy_next[i] = 1'b1;
            end
          default: begin
          end
        endcase
      end
      pp_next[i*PHRASE_W +: PHRASE_W] = phr_next[i];
      direct_phrase_cmd_next[i] = st_next[i] == CH_DIRECT_PHRASE_CMD;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST || (CE && dec_next == D_POWER_DOWN_CMD && dec_reg == D_FIRST)) begin
      // power-down returns every channel setting to its default
      for (int i = 0; i < NCH; i++) begin
        st_reg[i] <= CH_IDLE;
        phr_reg[i] <= '0;
        cnt_reg[i] <= '0;
      end
      loop_reg <= 4'h0;
      rdy_reg <= 4'hf;
      bsy_n_reg <= 4'hf;
      pp_reg <= '0;
      direct_phrase_cmd_reg <= 4'h0;
    end else if (CE) begin
      for (int i = 0; i < NCH; i++) begin
        st_reg[i] <= st_next[i];
        phr_reg[i] <= phr_next[i];
        cnt_reg[i] <= cnt_next[i];
      end
      loop_reg <= loop_next;
      rdy_reg <= rdy_next;
      bsy_n_reg <= bsy_n_next;
      pp_reg <= pp_next;
      direct_phrase_cmd_reg <= direct_phrase_cmd_next;
    end
  end

  assign LINK.cmd_ready_flag = rdy_reg;
  assign LINK.channel_busy_n = bsy_n_reg;
  assign LINK.powered_down = ~osc_reg;
  assign OSC_RUN = osc_reg;
  assign DIRECT_PHRASE_CMD_PHRASE = pp_reg;
  assign PLAYING = direct_phrase_cmd_reg;
endmodule

// [rtl/playback_host.sv]
// host end: turns user requests into command bytes on the link
// assumes flags from the decoder on the same REF_CLK
`timescale 1ns/10ps
module playback_host
#(
  parameter int HALT_WAIT_CYC = playback_pkg::BUSY_LOW_HALT_CYC
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CE,
  playback_link_if.host LINK,
  input wire logic REQ_VALID,
  input wire logic [3:0] REQ_OP,
  input wire logic [3:0] REQ_LOW,
  input wire logic [7:0] REQ_BYTE2,
  output logic REQ_READY,
  output logic REQ_REJECT,
  output logic HALT_RETRY
);
  import playback_pkg::*;

  typedef enum logic [2:0] {H_IDLE, H_SECOND, H_HALT_WAIT, H_CHECK} h_state_t;

  h_state_t st_reg, st_next;
  logic [7:0] byte_reg, byte_next, b2_reg, b2_next;
  logic val_reg, val_next, rdy_reg, rdy_next, rej_reg, rej_next;
  logic retry_reg, retry_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [3:0] halt_mask_reg, halt_mask_next;
  logic two;

  assign two = REQ_OP == OP_PHRASE_SELECT || REQ_OP == OP_DIRECT_PHRASE ||
    REQ_OP == OP_SILENCE_INSERT;

  always_comb begin
    st_next = st_reg;
    byte_next = byte_reg;
    b2_next = b2_reg;
    val_next = 1'b0;
    rdy_next = 1'b0;
    rej_next = 1'b0;
    retry_next = 1'b0;
    cnt_next = cnt_reg;
    halt_mask_next = halt_mask_reg;
    unique case (st_reg)
      H_IDLE: begin
        rdy_next = 1'b1;
        if (REQ_VALID && rdy_reg) begin
          rdy_next = 1'b0;
          // codes below the floor would give a gap under 20 ms
          if (REQ_OP == OP_SILENCE_INSERT && REQ_BYTE2 < SILENCE_CODE_MIN)
          begin
            rej_next = 1'b1;
            rdy_next = 1'b1;
          end else begin
            byte_next = {REQ_OP, REQ_LOW};
            b2_next = REQ_BYTE2;
            val_next = 1'b1;
            if (two) begin
              st_next = H_SECOND;
            end else if (REQ_OP == OP_HALT) begin
              halt_mask_next = REQ_LOW;
              cnt_next = CNT_W'(HALT_WAIT_CYC);
              st_next = H_HALT_WAIT;
            end else begin
              rdy_next = 1'b1;
            end
          end
        end
      end
      H_SECOND: begin
        byte_next = b2_reg;
        val_next = 1'b1;
        st_next = H_IDLE;
      end
      H_HALT_WAIT: begin
        if (cnt_reg == '0) begin
          st_next = H_CHECK;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      H_CHECK: begin
        if (&(LINK.channel_busy_n | ~halt_mask_reg)) begin
          st_next = H_IDLE;
        end else begin
          byte_next = {OP_HALT, halt_mask_reg};
          val_next = 1'b1;
          retry_next = 1'b1;
          cnt_next = CNT_W'(HALT_WAIT_CYC);
          st_next = H_HALT_WAIT;
        end
      end
      default: st_next = H_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      st_reg <= H_IDLE;
      byte_reg <= 8'h00;
      b2_reg <= 8'h00;
      val_reg <= 1'b0;
      rdy_reg <= 1'b0;
      rej_reg <= 1'b0;
      retry_reg <= 1'b0;
      cnt_reg <= '0;
      halt_mask_reg <= 4'h0;
    end else if (CE) begin
      st_reg <= st_next;
      byte_reg <= byte_next;
      b2_reg <= b2_next;
      val_reg <= val_next;
      rdy_reg <= rdy_next;
      rej_reg <= rej_next;
      retry_reg <= retry_next;
      cnt_reg <= cnt_next;
      halt_mask_reg <= halt_mask_next;
    end
  end

  assign LINK.cmd_byte = byte_reg;
  assign LINK.cmd_valid = val_reg;
  assign REQ_READY = rdy_reg;
  assign REQ_REJECT = rej_reg;
  assign HALT_RETRY = retry_reg;
endmodule

// [test/playback_command_decoder_asserts.sv]
// checker for the byte link between host and decoder ends
// assumes plain copies of the interface signals, CE held high
`timescale 1ns/10ps
module playback_command_decoder_asserts (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [7:0] cmd_byte,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_ready_flag,
  input wire logic [3:0] channel_busy_n,
  input wire logic powered_down
);
  import playback_pkg::*;
  logic pend_reg, pend_next, first;
  logic [7:0] b1_reg, b1_next;
  logic [3:0] op, mk;
  assign first = cmd_valid && !pend_reg;
  assign op = cmd_byte[7:4];
  assign mk = cmd_byte[3:0];
  // two-byte commands take the next strobe as data, never as opcode
  always_comb begin
    pend_next = pend_reg;
    b1_next = b1_reg;
    if (cmd_valid) pend_next = first && (op == OP_PHRASE_SELECT ||
      op == OP_DIRECT_PHRASE || op == OP_SILENCE_INSERT);
    if (first) b1_next = cmd_byte;
  end
  always_ff @(posedge REF_CLK) begin
    pend_reg <= RST ? 1'b0 : pend_next;
    b1_reg <= RST ? 8'h00 : b1_next;
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////////
  property p_direct_direct_phrase_cmd;
    cmd_valid && pend_reg && b1_reg[7:4] == OP_DIRECT_PHRASE &&
      cmd_ready_flag[b1_reg[1:0]] && !powered_down |=>
      !channel_busy_n[b1_reg[1:0]] && !cmd_ready_flag[b1_reg[1:0]];
  endproperty
  a_direct_direct_phrase_cmd: assert property (p_direct_direct_phrase_cmd)
    else $error("direct direct_phrase_cmd did not start");
  property p_launch;
    first && op == OP_LAUNCH && mk != 4'h0 && !powered_down &&
      (cmd_ready_flag & mk) == mk |=> (channel_busy_n & $past(mk)) == 4'h0;
  endproperty
  a_launch: assert property (p_launch)
    else $error("launch did not start channels");
  property p_halt;
    first && op == OP_HALT && mk != 4'h0 && !powered_down |=>
      (cmd_ready_flag & channel_busy_n & $past(mk)) == $past(mk);
  endproperty
  a_halt: assert property (p_halt)
    else $error("halted channel flags not high");
  property p_zero_mask;
    first && mk == 4'h0 && (op == OP_LAUNCH || op == OP_HALT ||
      op == OP_LOOP_SET || op == OP_LOOP_RELEASE) &&
      cmd_ready_flag == 4'hf && channel_busy_n == 4'hf |=>
      $stable(cmd_ready_flag) && $stable(channel_busy_n);
  endproperty
  a_zero_mask: assert property (p_zero_mask)
    else $error("zero mask command changed state");
  property p_pd_refused;
    first && op == OP_POWER_DOWN && channel_busy_n != 4'hf &&
      !powered_down |=> !powered_down [*3];
  endproperty
  a_pd_refused: assert property (p_pd_refused)
    else $error("power-down taken while busy");
  property p_pd_taken;
    first && op == OP_POWER_DOWN && channel_busy_n == 4'hf &&
      !powered_down |-> ##[1:40] powered_down;
  endproperty
  a_pd_taken: assert property (p_pd_taken)
    else $error("power-down never finished");
  property p_loop_release;
    first && op == OP_LOOP_RELEASE && mk != 4'h0 && !powered_down |=>
      (cmd_ready_flag & $past(mk)) == $past(mk);
  endproperty
  a_loop_release: assert property (p_loop_release)
    else $error("loop release left ready low");
  property p_halt_quiet;
    first && op == OP_HALT |=> !cmd_valid [*4];
  endproperty
  a_halt_quiet: assert property (p_halt_quiet)
    else $error("host sent a byte inside the halt wait");
endmodule

// [test/playback_command_decoder_tb.sv]
// self-checking bench: host end drives decoder end over the link
// assumes small model counts so the run stays short
`timescale 1ns/10ps
module playback_command_decoder_tb;
  import playback_pkg::*;
  localparam int PHR = 40;
  localparam int SIL = 4;
  logic ref_clk = 1'b0, rst = 1'b1, ce = 1'b1, req_valid = 1'b0;
  logic [3:0] req_op = 4'h0, req_low = 4'h0, playing;
  logic [7:0] req_byte2 = 8'h00, code;
  logic req_ready, req_reject, halt_retry, osc_run;
  logic [39:0] direct_phrase_cmd_phrase;
  logic [31:0] seed = 32'h16;
  logic [3:0] zops [4] = '{OP_LAUNCH, OP_HALT, OP_LOOP_SET, OP_LOOP_RELEASE};
  int n_errors = 0, checked = 0, n_rej = 0, n_byte = 0, n_rty = 0;
  playback_link_if link ();
  playback_command_decoder #(.PHRASE_CYC(PHR), .SILENCE_CYC(SIL),
    .PD_CYC(5)) i_playback_command_decoder (.REF_CLK(ref_clk), .RST(rst),
    .CE(ce), .LINK(link), .OSC_RUN(osc_run), .DIRECT_PHRASE_CMD_PHRASE(direct_phrase_cmd_phrase),
    .PLAYING(playing));
  playback_host #(.HALT_WAIT_CYC(4)) i_playback_host (.REF_CLK(ref_clk),
    .RST(rst), .CE(ce), .LINK(link), .REQ_VALID(req_valid),
    .REQ_OP(req_op), .REQ_LOW(req_low), .REQ_BYTE2(req_byte2),
    .REQ_READY(req_ready), .REQ_REJECT(req_reject),
    .HALT_RETRY(halt_retry));
  playback_command_decoder_asserts i_playback_command_decoder_asserts (
    .REF_CLK(ref_clk), .RST(rst), .cmd_byte(link.cmd_byte),
    .cmd_valid(link.cmd_valid), .cmd_ready_flag(link.cmd_ready_flag),
    .channel_busy_n(link.channel_busy_n), .powered_down(link.powered_down));
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    n_rej += (req_reject === 1'b1);
    n_byte += (link.cmd_valid === 1'b1);
    n_rty += (halt_retry === 1'b1);
  end
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic int gap_cyc(input logic [7:0] c);
    return (int'(c) + 1) * SIL;
  endfunction
  task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // request stands until the edge that samples REQ_READY high
  task automatic req(input logic [3:0] op, input logic [3:0] lo,
    input logic [7:0] b2);
    int i;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_op <= op;
    req_low <= lo;
    req_byte2 <= b2;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (req_ready !== 1'b1 && i < 200);
    req_valid <= 1'b0;
  endtask
  task automatic idle();
    int i;
    repeat (3) @(posedge ref_clk);
    for (i = 0; i < 200 && req_ready !== 1'b1; i++) @(posedge ref_clk);
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic close_out();
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #(20 * 20000);
    n_errors++;
    close_out();
  end
  initial begin
    logic [9:0] ph;
    logic [1:0] c;
    int n, k, i, b0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    cmp(direct_phrase_cmd_phrase, 40'h0);
    cmp(40'({link.cmd_ready_flag, link.channel_busy_n, playing, osc_run,
      link.powered_down}), 40'h3fc2);
    $display("reset test done");
    for (k = 0; k < 6; k++) begin
      seed = xs(seed);
      c = seed[1:0];
      ph = (k == 0) ? 10'h3ff : seed[17:8];
      req(OP_PHRASE_SELECT, {ph[9:8], c}, ph[7:0]);
      idle();
      cmp(40'(direct_phrase_cmd_phrase[c*10 +: 10]), 40'(ph));
      cmp(40'(playing), 40'h0);
      req(OP_LAUNCH, 4'h1 << c, 8'h00);
      idle();
      cmp(40'(playing), 40'(4'h1 << c));
      req(OP_HALT, 4'h1 << c, 8'h00);
      idle();
      cmp(40'({playing, link.cmd_ready_flag}), 40'h0f);
    end
    $display("select launch halt test done");
    foreach (zops[j]) begin
      req(zops[j], 4'h0, 8'h00);
      idle();
    end
    cmp(40'({link.cmd_ready_flag, link.channel_busy_n, playing}),
      40'hff0);
    req(OP_DIRECT_PHRASE, {ph[9:8], 2'h1}, ph[7:0]);
    idle();
    cmp(40'(playing), 40'h2);
    req(OP_HALT, 4'h0, 8'h00);
    req(OP_POWER_DOWN, 4'h0, 8'h00);
    idle();
    cmp(40'({playing, osc_run, link.powered_down}), 40'h0a);
    req(OP_HALT, 4'h2, 8'h00);
    idle();
    $display("zero mask and busy test done");
    b0 = n_byte;
    n = n_rej;
    req(OP_SILENCE_INSERT, 4'h4, 8'h03);
    idle();
    cmp(40'(n_rej - n), 40'h1);
    cmp(40'(n_byte - b0), 40'h0);
    // loop mode on channel 2 must not make the first gap repeat
    req(OP_LOOP_SET, 4'h4, 8'h00);
    idle();
    for (k = 0; k < 2; k++) begin
      seed = xs(seed);
      code = k ? 8'h04 + 8'(seed[2:0]) : 8'h04;
      req(OP_SILENCE_INSERT, 4'h4, code);
      n = 0;
      for (i = 0; i < 10 && link.channel_busy_n[2] !== 1'b0; i++)
        @(posedge ref_clk);
      while (link.channel_busy_n[2] === 1'b0 && n < 2000) begin
        @(posedge ref_clk);
        n++;
      end
      cmp(40'(n == gap_cyc(code) || n == gap_cyc(code) + 1), 40'h1);
      idle();
    end
    $display("silence test done");
    req(OP_LOOP_SET, 4'h8, 8'h00);
    idle();
    req(OP_DIRECT_PHRASE, 4'h3, 8'h5a);
    repeat (3 * PHR) @(posedge ref_clk);
    cmp(40'(playing[3]), 40'h1);
    req(OP_PHRASE_SELECT, 4'h3, 8'h11);
    idle();
    cmp(40'(direct_phrase_cmd_phrase[39:30]), 40'h05a);
    req(OP_LOOP_RELEASE, 4'h8, 8'h00);
    idle();
    cmp(40'(link.cmd_ready_flag[3]), 40'h1);
    repeat (2 * PHR) @(posedge ref_clk);
    cmp(40'(playing[3]), 40'h0);
    $display("loop test done");
    req(OP_POWER_DOWN, 4'h0, 8'h00);
    repeat (20) @(posedge ref_clk);
    cmp(40'({osc_run, link.powered_down}), 40'h1);
    cmp(direct_phrase_cmd_phrase, 40'h0);
    cmp(40'(n_rty), 40'h0);
    $display("power-down test done");
    close_out();
  end
endmodule
